/* core/asp_serial_port.v */
`timescale 1ns/1ns
`include "asp_defs.vh"
module asp_serial_port #(
    parameter WIDTH       = `ASP_RESULT_BITS,
    parameter CONV_CYCLES = `ASP_CONV_CYCLES
) (
    // Clock and reset
    input  wire             sys_clk_i,
    input  wire             resetn_i,
    // Pins from the host
    input  wire             conversion_start_i,
    input  wire             serial_clk_i,
    input  wire             serial_in_i,
    // Serial output pin, enable active low
    output reg              serial_out_o,
    output reg              serial_out_oe_n_o,
    // Samples from the converter core
    input  wire             sample_valid_i,
    output wire             sample_ready_o,
    input  wire [WIDTH-1:0] sample_data_i,
    // Status
    output reg              chain_mode_o,
    output reg              converting_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_READ = 3'b100;

    reg  [2:0]       state;
    reg  [1:0]       cnv_sync;
    reg  [1:0]       sck_sync;
    reg  [1:0]       sdi_sync;
    reg              cnv_d;
    reg              sck_d;
    reg  [15:0]      conv_cnt;
    reg  [WIDTH-1:0] shift;
    reg  [5:0]       bits_left;
    reg              busy_en;
    reg              sent_msb;
    wire             cnv;
    wire             sck;
    wire             serial_in;
    wire             cnv_rise;
    wire             sck_fall;
    wire             sel_low;
    wire             fifo_valid;
    wire [WIDTH-1:0] fifo_data;
    wire             fifo_take;

    assign cnv      = cnv_sync[1];
    assign sck      = sck_sync[1];
    assign serial_in      = sdi_sync[1];
    assign cnv_rise = cnv & ~cnv_d;
    assign sck_fall = ~sck & sck_d;
    assign sel_low  = ~cnv | ~serial_in;
    assign fifo_take = (state == ST_CONV) && (conv_cnt == 16'h0001);

    asp_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (`ASP_FIFO_DEPTH),
        .AW    (`ASP_FIFO_ADDR_BITS)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .in_data_i   (sample_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_take),
        .out_data_o  (fifo_data)
    );

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnv_sync <= 2'h0;
            sck_sync <= 2'h0;
            sdi_sync <= 2'h0;
            cnv_d    <= 1'b0;
            sck_d    <= 1'b0;
        end else begin
            cnv_sync <= {cnv_sync[0], conversion_start_i};
            sck_sync <= {sck_sync[0], serial_clk_i};
            sdi_sync <= {sdi_sync[0], serial_in_i};
            cnv_d    <= cnv;
            sck_d    <= sck;
        end
    end

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state             <= ST_IDLE;
            conv_cnt          <= 16'h0000;
            shift             <= {WIDTH{1'b0}};
            bits_left         <= 6'h00;
            busy_en           <= 1'b0;
            sent_msb          <= 1'b0;
            chain_mode_o      <= 1'b0;
            converting_o      <= 1'b0;
            serial_out_o      <= 1'b0;
            serial_out_oe_n_o <= 1'b1;
        end else begin
            if (cnv_rise) begin
                state        <= ST_CONV;
                conv_cnt     <= CONV_CYCLES[15:0];
                converting_o <= 1'b1;
                chain_mode_o <= ~serial_in;
                busy_en      <= 1'b0;
                sent_msb     <= 1'b0;
                bits_left    <= 6'h00;
                serial_out_oe_n_o <= serial_in;
                serial_out_o <= 1'b0;
            end else begin
                case (state)
                    ST_CONV: begin
                        conv_cnt <= conv_cnt - 16'h0001;
                        // Select line enables output while converting outside chain mode
                        if (!chain_mode_o) begin
                            serial_out_oe_n_o <= ~sel_low;
                        end
                        if (conv_cnt == 16'h0001) begin
                            state        <= ST_READ;
                            converting_o <= 1'b0;
                            shift        <= fifo_valid ? fifo_data : {WIDTH{1'b0}};
                            bits_left    <= WIDTH[5:0];
                            // Busy enabled if selected at completion outside chain mode
                            busy_en      <= ~chain_mode_o & sel_low;
                            if (~chain_mode_o & sel_low) begin
                                serial_out_o <= 1'b1;
                            end
                        end else begin
                            serial_out_o <= 1'b0;
                        end
                    end
                    ST_READ: begin
                        if (!chain_mode_o) begin
                            if (!sel_low) begin
                                serial_out_oe_n_o <= 1'b1;
                            end else begin
                                serial_out_oe_n_o <= 1'b0;
                                if (!sent_msb && !busy_en) begin
                                    serial_out_o <= shift[WIDTH-1];
                                    shift        <= {shift[WIDTH-2:0], 1'b0};
                                    bits_left    <= bits_left - 6'h01;
                                    sent_msb     <= 1'b1;
                                end else if (sck_fall) begin
                                    if (busy_en && !sent_msb) begin
                                        serial_out_o <= shift[WIDTH-1];
                                        shift        <= {shift[WIDTH-2:0], 1'b0};
                                        bits_left    <= bits_left - 6'h01;
                                        sent_msb     <= 1'b1;
                                    end else if (bits_left != 6'h00) begin
                                        serial_out_o <= shift[WIDTH-1];
                                        shift        <= {shift[WIDTH-2:0], 1'b0};
                                        bits_left    <= bits_left - 6'h01;
                                    end else begin
                                        // Falling edge after bit 0 ends the read
                                        serial_out_oe_n_o <= 1'b1;
                                        state             <= ST_IDLE;
                                    end
                                end
                            end
                        end else begin
                            // Host keeps start high; chain shift
                            serial_out_oe_n_o <= 1'b0;
                            // Serial_in is taken only on a falling edge, so nothing extra enters the chain
                            if (!sent_msb) begin
                                serial_out_o <= shift[WIDTH-1];
                                sent_msb     <= 1'b1;
                            end else if (sck_fall) begin
                                serial_out_o <= shift[WIDTH-2];
                                shift        <= {shift[WIDTH-2:0], serial_in};
                            end
                        end
                    end
                    default: begin
                        serial_out_oe_n_o <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

/* core/asp_defs.vh */
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
// Result width and daisy-chain delay in serial clock cycles
`define ASP_RESULT_BITS    16
`define ASP_CHAIN_DELAY    16
// Conversion time in ns and its cycle count at 250 MHz
`define ASP_CONV_TIME_NS   1000
`define ASP_CLK_PERIOD_NS  4
`define ASP_CONV_CYCLES    (`ASP_CONV_TIME_NS / `ASP_CLK_PERIOD_NS)
// Result FIFO shape
`define ASP_FIFO_DEPTH     32
`define ASP_FIFO_ADDR_BITS 5
`endif

/* core/asp_fifo.v */
`timescale 1ns/1ns
module asp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             sys_clk_i,
    input  wire             resetn_i,
    // Fill side
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr;
    reg [AW:0]      rd_ptr;
    wire            full;
    wire            empty;
    wire            do_wr;
    wire            do_rd;

    assign empty       = (wr_ptr == rd_ptr);
    assign full        = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign do_wr       = in_valid_i & ~full;
    assign do_rd       = out_ready_i & ~empty;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];

    always @(posedge sys_clk_i) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

/* verification/asp_host_model.sv */
`timescale 1ns/1ns
module asp_host_model (
    // Clock
    input  wire sys_clk_i,
    // Pins to and from the converter
    output reg  conversion_start_o,
    output reg  serial_clk_o,
    output reg  serial_in_o,
    input  wire serial_out_i
);
    initial begin
        conversion_start_o = 1'b0;
        serial_clk_o       = 1'b0;
        serial_in_o        = 1'b1;
    end
    task start(input chain);
        begin
            serial_in_o <= ~chain;
            conversion_start_o <= 1'b0;
            repeat (4) @(posedge sys_clk_i);
            conversion_start_o <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
        end
    endtask
    task sel(input v);
        begin
            serial_in_o <= v;
            repeat (6) @(posedge sys_clk_i);
        end
    endtask
    task frame(input integer n, input chain, input [47:0] din, output [47:0] dout);
        integer i;
        begin
            dout = 48'h0;
            for (i = 0; i < n; i = i + 1) begin
                serial_clk_o <= 1'b1;
                if (chain) serial_in_o <= din[n-1-i];
                repeat (4) @(posedge sys_clk_i);
                dout = {dout[46:0], serial_out_i};
                serial_clk_o <= 1'b0;
                repeat (4) @(posedge sys_clk_i);
            end
        end
    endtask
endmodule

/* verification/asp_serial_port_checker.sv */
`timescale 1ns/1ns
module asp_serial_port_checker #(
    parameter CONV_CYCLES = 250
) (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire conversion_start_i,
    input wire serial_clk_i,
    input wire serial_in_i,
    input wire serial_out_o,
    input wire serial_out_oe_n_o,
    input wire chain_mode_o,
    input wire converting_o
);
    reg [15:0] run;
    always @(posedge sys_clk_i or negedge resetn_i)
        if (!resetn_i) run <= 16'h0;
        else run <= converting_o ? run + 16'h1 : 16'h0;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence start_sel; $rose(conversion_start_i) && serial_in_i; endsequence
    sequence start_chn; $rose(conversion_start_i) && !serial_in_i; endsequence
    conv_start_a: assert property ($rose(conversion_start_i) |-> ##[3:5] converting_o)
        else $error("conversion did not start");
    conv_len_a: assert property ($fell(converting_o) |-> run == CONV_CYCLES)
        else $error("conversion length wrong");
    mode_chain_a: assert property (start_chn |-> ##6 chain_mode_o)
        else $error("chain mode not taken");
    mode_sel_a: assert property (start_sel |-> ##6 !chain_mode_o)
        else $error("select mode not taken");
    busy_done_a: assert property ($fell(converting_o) && !chain_mode_o && !serial_out_oe_n_o |-> ##[0:2] serial_out_o)
        else $error("busy end not shown");
    busy_low_a: assert property (converting_o && $past(converting_o) && !serial_out_oe_n_o |-> !serial_out_o)
        else $error("output high while converting");
    select_en_a: assert property ($fell(serial_in_i) && conversion_start_i && !chain_mode_o && !converting_o
        |-> ##[1:6] !serial_out_oe_n_o)
        else $error("output not enabled");
    release_out_a: assert property ($rose(serial_in_i) && conversion_start_i && !chain_mode_o
        |-> ##[1:6] serial_out_oe_n_o)
        else $error("output not released");
    fall_shift_a: assert property ($changed(serial_out_o) && !serial_out_oe_n_o |-> !$past(serial_clk_i))
        else $error("output moved outside falling edge");
endmodule
bind asp_serial_port asp_serial_port_checker #(.CONV_CYCLES(CONV_CYCLES)) u_checker (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .conversion_start_i(conversion_start_i),
    .serial_clk_i(serial_clk_i), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
    .serial_out_oe_n_o(serial_out_oe_n_o), .chain_mode_o(chain_mode_o), .converting_o(converting_o)
);

/* verification/testbench.sv */
`timescale 1ns/1ns
module testbench;
    reg         sys_clk_i    = 1'b0;
    reg         resetn_i     = 1'b0;
    reg         sample_valid = 1'b0;
    reg  [15:0] sample_data  = 16'h0;
    wire        cnv, sck, serial_in, serial_out, oe_n, ready, chain, conv;
    integer     n_errors     = 0;
    integer     checks_done  = 0;
    integer     i, k;
    reg  [31:0] seed         = 32'he9ac;
    reg  [47:0] got;
    reg  [15:0] w;
    reg  [15:0] q [$];
    always #2 sys_clk_i = ~sys_clk_i;
    asp_serial_port #(.CONV_CYCLES(20)) uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .conversion_start_i(cnv), .serial_clk_i(sck), .serial_in_i(serial_in), .serial_out_o(serial_out),
        .serial_out_oe_n_o(oe_n), .sample_valid_i(sample_valid), .sample_ready_o(ready),
        .sample_data_i(sample_data), .chain_mode_o(chain), .converting_o(conv));
    asp_host_model u_host (.sys_clk_i(sys_clk_i), .conversion_start_o(cnv), .serial_clk_o(sck),
        .serial_in_o(serial_in), .serial_out_i(serial_out));
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task check(input [8*12:1] name, input [47:0] seen, input [47:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("Error %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task wait_conv(input v);
        integer t;
        begin
            for (t = 0; t < 200 && conv !== v; t = t + 1) @(posedge sys_clk_i);
            if (conv !== v) begin
                n_errors = n_errors + 1;
                summarize;
            end
        end
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        for (i = 0; i < 33; i = i + 1) begin
            seed = lfsr(seed);
            sample_valid <= 1'b1;
            sample_data  <= (i == 0) ? 16'h8001 : seed[15:0];
            @(posedge sys_clk_i);
            if (ready) q.push_back(sample_data);
        end
        sample_valid <= 1'b0;
        check("fifo full", {47'h0, ready}, 48'h0);
        check("fifo count", q.size(), 48'h20);
        $display("fill test done");
        for (i = 0; i < 34; i = i + 1) begin
            seed = lfsr(seed);
            w = (q.size() > 0) ? q.pop_front() : 16'h0;
            k = (i < 3) ? i : seed[17:16];
            u_host.start(k == 0);
            wait_conv(1'b1);
            repeat (2) @(posedge sys_clk_i);
            check("mode", {47'h0, chain}, {47'h0, k == 0});
            if (k == 0) begin
                wait_conv(1'b0);
                repeat (6) @(posedge sys_clk_i);
                u_host.frame(32, 1'b1, {16'h0, seed}, got);
                check("chain data", got, {16'h0, w, seed[31:16]});
            end else if (k == 1) begin
                wait_conv(1'b0);
                repeat (4) @(posedge sys_clk_i);
                u_host.sel(1'b0);
                check("enable", {47'h0, oe_n}, 48'h0);
                u_host.frame(16, 1'b0, 48'h0, got);
                check("select data", got, {32'h0, w});
                repeat (6) @(posedge sys_clk_i);
                check("release", {47'h0, oe_n}, 48'h1);
                u_host.sel(1'b1);
            end else begin
                u_host.sel(1'b0);
                check("busy low", {46'h0, oe_n, serial_out}, 48'h0);
                wait_conv(1'b0);
                repeat (4) @(posedge sys_clk_i);
                u_host.frame(17, 1'b0, 48'h0, got);
                check("busy data", got, {31'h0, 1'b1, w});
                u_host.sel(1'b1);
                check("deselect", {47'h0, oe_n}, 48'h1);
            end
            $display("conversion %0d mode %0d done", i, k);
        end
        summarize;
    end
endmodule
